// >>> src/adcct_seq.sv
// Purpose: Times one 10-bit successive approximation conversion
// Assumes: clk is the CPU clock; each edge pair is two half_cpu_period units
// Notes: Comparator answers in the same cycle as the trial code is shown
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Start runs a sample phase of two sample clock periods.
// - Ten successive approximation steps, one step period each, one per bit.
// - Four equalizing step periods follow the bit decisions.
// - Total is 14 step periods plus 2 sample periods plus 4 units.
// - Step select 00=24, 10=96, 11=48 units; 01 reserved.
// - Sample select gives 1, 2, 4 or 8 step periods.
// - Both selects sit in the upper nibble of converter_control_reg.
// - Below ground reads zero; above reference saturates at full scale.
// - Sample is held once the sample phase ends.
// - Timing is counted in half CPU clock units.
module adcct_seq #(
   parameter int RES = adcct_pkg::RES_BITS
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] converter_control_reg,
   input wire logic start,
   input wire logic comp_above,
   input wire logic below_gnd,
   input wire logic above_ref,
   output logic sample_en,
   output logic hold,
   output logic [RES-1:0] trial_code,
   output logic busy,
   output logic conv_done,
   output logic reserved_code,
   output logic [RES-1:0] result
);
   // One result bit per decision step; other widths cannot be served
   if (RES != adcct_pkg::BIT_STEPS) begin : g_bad_res
      $error("RES must equal the number of bit steps");
   end

   // Step period in clk cycles, two half_cpu_period units per cycle
   function automatic logic [6:0] step_cycles(input logic [1:0] sel);
      logic [6:0] u;
      u = 7'(adcct_pkg::STEP_UNITS_00);
      if (sel == 2'b10) begin
         u = 7'(adcct_pkg::STEP_UNITS_10);
      end else if (sel == 2'b11) begin
         u = 7'(adcct_pkg::STEP_UNITS_11);
      end
      return 7'(u / adcct_pkg::UNITS_PER_CLK);
   endfunction

   localparam logic [3:0] LAST_BIT = 4'(adcct_pkg::BIT_STEPS - 1);
   localparam logic [3:0] LAST_EQ = 4'(adcct_pkg::EQ_STEPS - 1);
   localparam logic [6:0] TAIL_CYC = 7'(adcct_pkg::TAIL_UNITS / adcct_pkg::UNITS_PER_CLK);

   adcct_pkg::adcct_state_t state, next_state;
   logic [1:0] ccs, next_ccs;
   logic [1:0] scs, next_scs;
   logic [6:0] cyc, next_cyc;
   logic [4:0] steps, next_steps;
   logic [3:0] bit_idx, next_bit_idx;
   logic [RES-1:0] sar, next_sar;
   logic next_sample_en, next_hold, next_busy, next_done;
   logic [RES-1:0] final_code;
   logic wr_res;
   logic [6:0] step_len;
   logic [4:0] sample_steps;
   logic step_end;

   always_comb begin
      step_len = step_cycles(ccs);
      sample_steps = 5'(1) << scs;
      step_end = (cyc == step_len - 7'd1);
      next_state = state;
      next_ccs = ccs;
      next_scs = scs;
      next_cyc = cyc;
      next_steps = steps;
      next_bit_idx = bit_idx;
      next_sar = sar;
      wr_res = 1'b0;
      next_done = 1'b0;
      final_code = sar;
      if (above_ref) begin
         final_code = '1;
      end else if (below_gnd) begin
         final_code = '0;
      end
      case (state)
         adcct_pkg::ADCCT_IDLE: begin
            if (start) begin
               // Fields latched so a mid-conversion write cannot skew timing
               next_ccs = converter_control_reg[adcct_pkg::CCS_LSB +: 2];
               next_scs = converter_control_reg[adcct_pkg::SCS_LSB +: 2];
               next_cyc = '0;
               next_steps = '0;
               next_sar = '0;
               next_state = adcct_pkg::ADCCT_SAMPLE;
            end
         end
         adcct_pkg::ADCCT_SAMPLE: begin
            next_cyc = step_end ? 7'd0 : 7'(cyc + 7'd1);
            if (step_end) begin
               next_steps = 5'(steps + 5'd1);
               // Two sample clock periods of 1..8 step periods each
               if (steps == 5'((sample_steps << 1) - 5'd1)) begin
                  next_steps = '0;
                  next_bit_idx = LAST_BIT;
                  next_sar = RES'(1) << LAST_BIT;
                  next_state = adcct_pkg::ADCCT_BITS;
               end
            end
         end
         adcct_pkg::ADCCT_BITS: begin
            next_cyc = step_end ? 7'd0 : 7'(cyc + 7'd1);
            if (step_end) begin
               next_sar = sar;
               if (!comp_above) begin
                  next_sar[bit_idx] = 1'b0;
               end
               if (bit_idx == 4'd0) begin
                  next_steps = '0;
                  next_state = adcct_pkg::ADCCT_EQUAL;
               end else begin
                  next_bit_idx = 4'(bit_idx - 4'd1);
                  next_sar[bit_idx - 4'd1] = 1'b1;
               end
            end
         end
         adcct_pkg::ADCCT_EQUAL: begin
            next_cyc = step_end ? 7'd0 : 7'(cyc + 7'd1);
            if (step_end) begin
               next_steps = 5'(steps + 5'd1);
               if (steps[3:0] == LAST_EQ) begin
                  next_state = adcct_pkg::ADCCT_TAIL;
               end
            end
         end
         adcct_pkg::ADCCT_TAIL: begin
            next_cyc = 7'(cyc + 7'd1);
            if (cyc == TAIL_CYC - 7'd1) begin
               wr_res = 1'b1;
               next_done = 1'b1;
               next_cyc = '0;
               next_state = adcct_pkg::ADCCT_IDLE;
            end
         end
         default: begin
            next_state = adcct_pkg::ADCCT_IDLE;
         end
      endcase
      next_sample_en = (next_state == adcct_pkg::ADCCT_SAMPLE);
      next_hold = (next_state != adcct_pkg::ADCCT_IDLE) && !next_sample_en;
      next_busy = (next_state != adcct_pkg::ADCCT_IDLE);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= adcct_pkg::ADCCT_IDLE;
         ccs <= adcct_pkg::CTRL_RESET[adcct_pkg::CCS_LSB +: 2];
         scs <= adcct_pkg::CTRL_RESET[adcct_pkg::SCS_LSB +: 2];
         cyc <= '0;
         steps <= '0;
         bit_idx <= '0;
         sar <= '0;
         sample_en <= 1'b0;
         hold <= 1'b0;
         busy <= 1'b0;
         conv_done <= 1'b0;
         trial_code <= '0;
         reserved_code <= 1'b0;
      end else begin
         state <= next_state;
         ccs <= next_ccs;
         scs <= next_scs;
         cyc <= next_cyc;
         steps <= next_steps;
         bit_idx <= next_bit_idx;
         sar <= next_sar;
         sample_en <= next_sample_en;
         hold <= next_hold;
         busy <= next_busy;
         conv_done <= next_done;
         trial_code <= next_sar;
         // Reserved step code runs as 00; flagged so software can see it
         reserved_code <= (converter_control_reg[adcct_pkg::CCS_LSB +: 2] == 2'b01);
      end
   end

   adcct_result_mem #(
      .WIDTH(RES)
   ) u_result (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr_res),
      .wr_data(final_code),
      .rd_data(result)
   );
endmodule // adcct_seq
`default_nettype wire

// >>> src/adcct_pkg.sv
// Purpose: Shared constants for the conversion timing sequencer
// Assumes: One clk cycle stands for two half_cpu_period units
// Notes: Timing counts are in half_cpu_period units
`default_nettype none
package adcct_pkg;
   localparam int RES_BITS = 10;
   localparam int BIT_STEPS = 10;
   localparam int EQ_STEPS = 4;
   localparam int SAMPLE_PERIODS = 2;
   localparam int TAIL_UNITS = 4;
   localparam int UNITS_PER_CLK = 2;
   localparam int STEP_UNITS_00 = 24;
   localparam int STEP_UNITS_10 = 96;
   localparam int STEP_UNITS_11 = 48;
   localparam int CCS_LSB = 4;
   localparam int SCS_LSB = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CLK_PERIOD_NS = 40;
   typedef enum logic [4:0] {
      ADCCT_IDLE = 5'b00001,
      ADCCT_SAMPLE = 5'b00010,
      ADCCT_BITS = 5'b00100,
      ADCCT_EQUAL = 5'b01000,
      ADCCT_TAIL = 5'b10000
   } adcct_state_t;
endpackage
`default_nettype wire

// >>> src/adcct_result_mem.sv
// Purpose: Result holding register with registered read data
// Assumes: Written once per finished conversion
// Notes: Keeps the value until the next write
`timescale 1ns/10ps
`default_nettype none
module adcct_result_mem #(
   parameter int WIDTH = 10
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] next_rd_data;
   always_comb begin
      next_rd_data = wr_en ? wr_data : rd_data;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data <= '0;
      end else begin
         rd_data <= next_rd_data;
      end
   end
endmodule // adcct_result_mem
`default_nettype wire

// >>> dv/adcct_comp_model.sv
// Purpose: Comparator and sample capacitor model
// Assumes: vin is the input as a code; lo and hi flag overrange
// Notes: Toggles when idle so a stale answer is never read back
`timescale 1ns/10ps
`default_nettype none
module adcct_comp_model (
   input wire logic clk,
   input wire logic sample_en,
   input wire logic hold,
   input wire logic [9:0] trial_code,
   input wire logic [9:0] vin,
   input wire logic lo,
   input wire logic hi,
   output logic comp_above,
   output logic below_gnd,
   output logic above_ref
);
   logic [11:0] held = 12'h000;
   logic tog = 1'b0;
   always @(posedge clk) begin
      tog <= ~tog;
      if (sample_en) held <= {lo, hi, vin};
   end
   assign comp_above = hold ? (held[9:0] >= trial_code) : tog;
   assign below_gnd = held[11] & hold;
   assign above_ref = held[10] & hold;
endmodule // adcct_comp_model
`default_nettype wire

// >>> dv/adcct_seq_properties.sv
// Purpose: Port properties of the conversion sequencer
// Assumes: One clk domain, nrst async active low
// Notes: Sample phase is only bounded from below here
`timescale 1ns/10ps
`default_nettype none
module adcct_seq_chk #(
   parameter int RES = 10
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] converter_control_reg,
   input wire logic start,
   input wire logic sample_en,
   input wire logic hold,
   input wire logic [RES-1:0] trial_code,
   input wire logic busy,
   input wire logic conv_done,
   input wire logic reserved_code,
   input wire logic [RES-1:0] result
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_START_TAKEN: assert property (start && !busy |=> busy && sample_en)
      else $error("start not taken");
   AST_SAMPLE_LEN: assert property ($rose(sample_en) |-> sample_en[*8])
      else $error("sample phase too short");
   AST_HOLD_ENTRY: assert property ($fell(sample_en) |-> hold && trial_code == {1'b1, {(RES-1){1'b0}}})
      else $error("bad hold entry");
   AST_NO_OVERLAP: assert property (sample_en |-> !hold && busy)
      else $error("sample while holding");
   AST_DONE_PULSE: assert property (conv_done |=> !conv_done)
      else $error("done too long");
   AST_DONE_END: assert property (conv_done |-> !busy && !hold && $past(busy))
      else $error("bad done state");
   AST_RESULT_HOLD: assert property (!conv_done |-> $stable(result))
      else $error("result moved");
   AST_RESERVED: assert property (converter_control_reg[5:4] == 2'h1 |=> reserved_code)
      else $error("reserved code missed");
endmodule // adcct_seq_chk
bind adcct_seq adcct_seq_chk #(.RES(RES)) chk_u (.clk, .nrst, .converter_control_reg,
   .start, .sample_en, .hold, .trial_code, .busy, .conv_done, .reserved_code, .result);
`default_nettype wire

// >>> dv/adcct_seq_tb.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Done is seen at the documented total, counted from the start edge
// Notes: Input is moved during hold to show the sample is kept
`timescale 1ns/10ps
`default_nettype none
module adcct_seq_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] ctl = 8'h00;
   logic start = 1'b0;
   logic [9:0] vin = 10'h000;
   logic lo = 1'b0;
   logic hi = 1'b0;
   logic comp_above, below_gnd, above_ref, sample_en, hold, busy, conv_done, reserved_code;
   logic [9:0] trial_code, result;
   int fails = 0;
   int n_checks = 0;
   adcct_seq dut_u (.clk, .nrst, .converter_control_reg(ctl), .start, .comp_above, .below_gnd,
      .above_ref, .sample_en, .hold, .trial_code, .busy, .conv_done, .reserved_code, .result);
   adcct_comp_model comp_u (.clk, .sample_en, .hold, .trial_code, .vin, .lo, .hi,
      .comp_above, .below_gnd, .above_ref);
   initial begin
      forever #20 clk = ~clk;
   end
   function automatic int cyc(input logic [1:0] c, input logic [1:0] s);
      int u;
      u = (c == 2'h2) ? adcct_pkg::STEP_UNITS_10 : adcct_pkg::STEP_UNITS_00;
      u = (c == 2'h3) ? adcct_pkg::STEP_UNITS_11 : u;
      u = (adcct_pkg::BIT_STEPS + adcct_pkg::EQ_STEPS) * u
         + adcct_pkg::SAMPLE_PERIODS * (1 << s) * u + adcct_pkg::TAIL_UNITS;
      return u / adcct_pkg::UNITS_PER_CLK;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conv(input logic [7:0] c, input logic [9:0] v, input int poke,
         input logic [9:0] er);
      int n;
      n = 0;
      ctl = c;
      vin = v;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      while (conv_done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1 n++;
         if (n == poke) start = 1'b1;
         else if (n == poke + 1) start = 1'b0;
         if (hold === 1'b1) vin = ~v;
      end
      check(n, cyc(c[5:4], c[7:6]));
      check(result, er);
   endtask
   task automatic test_step();
      for (int c = 0; c < 4; c++) begin
         conv({2'h0, c[1:0], 4'h0}, 10'h2a5, 0, 10'h2a5);
         check(reserved_code, c == 1);
      end
      $display("test_step done");
   endtask
   task automatic test_sample();
      for (int s = 0; s < 4; s++) begin
         conv({s[1:0], 6'h00}, 10'h15a, 0, 10'h15a);
      end
      $display("test_sample done");
   endtask
   task automatic test_range();
      lo = 1'b1;
      conv(8'h00, 10'h155, 0, 10'h000);
      lo = 1'b0;
      hi = 1'b1;
      conv(8'h30, 10'h000, 0, 10'h3ff);
      hi = 1'b0;
      conv(8'h00, 10'h3ff, 0, 10'h3ff);
      conv(8'h00, 10'h000, 0, 10'h000);
      $display("test_range done");
   endtask
   task automatic test_busy();
      conv(8'h40, 10'h0f0, 60, 10'h0f0);
      repeat (2) @(posedge clk);
      #1 check(busy, 1'b0);
      $display("test_busy done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #(adcct_pkg::CLK_PERIOD_NS * 20000);
      fails++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      #1 nrst = 1'b1;
      test_step();
      test_sample();
      test_range();
      test_busy();
      print_verdict();
   end
endmodule // adcct_seq_tb
`default_nettype wire
